//--- coef_bank_map.svh
// offsets, field positions, reset values and timing counts of the
// coefficient bank switcher; included by bare name, definitions only
`ifndef COEF_BANK_MAP_SVH
`define COEF_BANK_MAP_SVH

// register offsets on the control port
`define BANK_CTRL_ADDR 8'h40
`define VOL_RAMP_ADDR 8'hD0

// bank control fields
`define SEL_LSB 16
`define SEL_MSB 18
`define ASSOC1_LSB 8
`define ASSOC2_LSB 0
`define ACTIVE_LSB 20
`define BUSY_BIT 22
`define SEL_RST 3'h0
`define ASSOC1_RST 8'hFF
`define ASSOC2_RST 8'h00

// volume ramp configuration fields
`define STEPS_LSB 0
`define STEPS_RST 2'h2
`define STEPS_512 12'h200
`define STEPS_1024 12'h400
`define STEPS_2048 12'h800

// sample periods per ramp step, and the load extension limit
`define DIV_NORMAL 5'h04
`define DIV_DOUBLE 5'h08
`define DIV_QUAD 5'h10
`define EXT_MAX 2'h3

// silent start after clocks return, and the processing clock rate
`define SILENT_START_MS 5
`define CLK_KHZ 250000
`define SILENT_START_CYC (`SILENT_START_MS * `CLK_KHZ)

`endif

//--- coef_bank_mem.sv
// three-bank coefficient store with registered read data
// assumes one clock; after reset it sweeps all three banks to zero and
// ignores writes while clear_busy_q is high
`timescale 1ns/1ps
module coef_bank_mem #(
  parameter int WORDS = 512,
  parameter int DATA_W = 32
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [1:0] wr_bank,
  input wire logic [$clog2(WORDS)-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [1:0] rd_bank,
  input wire logic [$clog2(WORDS)-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data_q,
  output logic clear_busy_q
);
  localparam int AW = $clog2(WORDS);
  localparam logic [AW+1:0] LAST = (AW+2)'(3 * WORDS - 1);

  if (WORDS != (1 << AW)) begin : g_chk
    $error("coef_bank_mem: WORDS must be a power of two");
  end

  logic [DATA_W-1:0] mem [0:4*WORDS-1];
  logic [AW+1:0] clr_ptr_q;

  // sweep pointer walks all three banks once after reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clr_ptr_q <= '0;
      clear_busy_q <= 1'b1;
    end else if (clear_busy_q) begin
      clr_ptr_q <= clr_ptr_q + (AW+2)'(1);
      clear_busy_q <= (clr_ptr_q != LAST);
    end
  end

  // storage: zero during the sweep, else the requested word
  always_ff @(posedge ref_clk) begin
    if (clear_busy_q) begin
      mem[clr_ptr_q] <= '0;
    end else if (wr_en) begin
      mem[{wr_bank, wr_addr}] <= wr_data;
    end
  end

  // read data leaves from a register
  always_ff @(posedge ref_clk) begin
    rd_data_q <= mem[{rd_bank, rd_addr}];
  end
endmodule

//--- coef_bank_pkg.sv
// types shared by the coefficient bank switcher, its bench and the host controller model
// assumes coef_bank_map.svh is compiled alongside for the numbers
package coef_bank_pkg;

  // bank-selection field codes
  typedef enum logic [2:0] {
    SEL_BANK1 = 3'h0,
    SEL_BANK2 = 3'h1,
    SEL_BANK3 = 3'h2,
    SEL_AUTO = 3'h3,
    SEL_SET1 = 3'h4,
    SEL_SET2 = 3'h5,
    SEL_SET3 = 3'h6,
    SEL_RSVD = 3'h7
  } bank_sel_t;

  // detected data rates, one association bit each (bit 7 = 32 kHz)
  typedef enum logic [2:0] {
    RATE_32 = 3'h0,
    RATE_38 = 3'h1,
    RATE_44K1 = 3'h2,
    RATE_48 = 3'h3,
    RATE_88K2 = 3'h4,
    RATE_96 = 3'h5,
    RATE_176K4 = 3'h6,
    RATE_192 = 3'h7
  } rate_t;

  // switch sequence, gray coded along idle-down-swap-up
  typedef enum logic [2:0] {
    SW_IDLE = 3'h0,
    SW_DOWN = 3'h1,
    SW_SWAP = 3'h3,
    SW_UP = 3'h2,
    SW_SILENT = 3'h6
  } sw_state_t;

  // control register access from the serial control front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // coefficient write from the serial control front end
  typedef struct packed {
    logic wr;
    logic [8:0] addr;
    logic [31:0] data;
  } coef_req_t;

  // per-channel volume command
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [7:0] level;
  } vol_cmd_t;

endpackage

//--- coef_bank_switcher.sv
// bank selection, bank-set protection and the soft mute ramp around
// each bank switch; assumes a rate detector supplies the rate code, a
// one-cycle sample_tick per sample period and the clock-present level
`timescale 1ns/1ps
`include "coef_bank_map.svh"
// Function
// - ramps are linear with 512, 1024 or 2048 steps from volume_ramp_config
// - one step per 4, 8 or 16 sample periods by speed
// - load may stretch steps one to three samples, total up to one eighth
// - eight data rates are recognised for detection and association
// - three banks each hold seven biquads of five per channel
// - banks also hold loudness, compressor and tone selections
// - reset gives manual bank 1; banks two and three read zero
// - manual mode coefficient writes go to the selected bank
// - streaming switch ramps to mute, swaps, then ramps back up
// - switch mute overrides pending unmute or volume commands
// - unmute returns each channel to its last commanded volume
// - stopped clocks switch at once; restart runs 5 ms silence
// - code 3 enables automatic selection by detected rate
// - automatic: bank 1 if associated, else bank 2, else bank 3
// - bank 1 association resets to ones, bank 2 to zeros
// - automatic mode coefficient writes go to the bank in use
// - codes 4, 5, 6 steer writes to banks 1, 2, 3
// - bank-set blocks every switch, rate and clock triggered too
// - control accepted and status given without a master clock
module coef_bank_switcher #(
  parameter int BANK_WORDS = 512,
  parameter int SILENT_CYC = `SILENT_START_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire coef_bank_pkg::reg_req_t reg_req,
  output logic [31:0] reg_rdata_q,
  input wire coef_bank_pkg::coef_req_t coef_req,
  input wire logic [8:0] coef_rd_addr,
  output logic [31:0] coef_rd_data_q,
  input wire coef_bank_pkg::rate_t det_rate,
  input wire logic sample_tick,
  input wire logic clk_present,
  input wire logic load_stall,
  input wire logic [7:0] mute_cmd,
  input wire logic [7:0] unmute_cmd,
  input wire coef_bank_pkg::vol_cmd_t vol_cmd,
  output logic [11:0] switch_gain_q,
  output logic [11:0] ramp_full_q,
  output logic [7:0] chan_mute_q,
  output logic [63:0] chan_vol_q,
  output logic [1:0] active_bank_q,
  output logic switch_busy_q,
  output logic init_busy_q
);
  // bank image: 8 x 35 biquad, 5 loudness, 12 compressor, 10 tone
  if (BANK_WORDS < 307 || BANK_WORDS > 512) begin : g_chk
    $error("coef_bank_switcher: BANK_WORDS must be 307 to 512");
  end
  if (SILENT_CYC < 1) begin : g_chk_silent
    $error("coef_bank_switcher: SILENT_CYC must be positive");
  end

  localparam int AW = $clog2(BANK_WORDS);

  coef_bank_pkg::bank_sel_t sel_q;
  coef_bank_pkg::sw_state_t fsm_q, fsm_d;
  logic [7:0] assoc1_q, assoc2_q;
  logic [1:0] steps_code_q;
  logic [1:0] target_q;
  logic [11:0] gain_q;
  logic [4:0] tick_cnt_q;
  logic [1:0] ext_step_q;
  logic [12:0] ext_used_q;
  logic [31:0] silent_cnt_q;
  logic [7:0] user_mute_q;
  logic [7:0] vol_q [0:7];
  logic step_q;
  logic mem_busy;

  // field decode of the two registers
  wire wr_bank_ctrl = reg_req.wr && reg_req.addr == `BANK_CTRL_ADDR;
  wire wr_vol_ramp = reg_req.wr && reg_req.addr == `VOL_RAMP_ADDR;
  wire [2:0] wsel = reg_req.wdata[`SEL_MSB:`SEL_LSB];
  wire [1:0] wsteps = reg_req.wdata[`STEPS_LSB+1:`STEPS_LSB];

  // selection mode decode
  wire bank_set_mode = sel_q == coef_bank_pkg::SEL_SET1 ||
                       sel_q == coef_bank_pkg::SEL_SET2 ||
                       sel_q == coef_bank_pkg::SEL_SET3;
  wire auto_mode = sel_q == coef_bank_pkg::SEL_AUTO;
  wire [2:0] rate_bit = 3'h7 - 3'(det_rate);
  wire rate_in_b1 = assoc1_q[rate_bit];
  wire rate_in_b2 = assoc2_q[rate_bit];
  wire [1:0] auto_bank = rate_in_b1 ? 2'h0 :
                         rate_in_b2 ? 2'h1 : 2'h2;
  wire [1:0] want_bank = auto_mode ? auto_bank : sel_q[1:0];
  wire switch_req = !bank_set_mode && sel_q != coef_bank_pkg::SEL_RSVD &&
                    want_bank != active_bank_q && !mem_busy;

  // coefficient writes: bank-set target, else the bank in use
  wire [1:0] wr_bank = bank_set_mode ? 2'(sel_q - coef_bank_pkg::SEL_SET1)
                                     : active_bank_q;

  // ramp length and step period from the configuration and rate
  wire [11:0] ramp_full = steps_code_q == 2'h0 ? `STEPS_512 :
                          steps_code_q == 2'h1 ? `STEPS_1024 :
                          `STEPS_2048;
  wire [4:0] base_div = det_rate <= coef_bank_pkg::RATE_48 ? `DIV_NORMAL :
                        det_rate <= coef_bank_pkg::RATE_96 ? `DIV_DOUBLE :
                        `DIV_QUAD;
  // stretch budget: one eighth of the nominal ramp in sample periods
  wire [16:0] ramp_samples = 17'(ramp_full) * 17'(base_div);
  wire [12:0] ext_budget = ramp_samples[15:3];

  // step divider with bounded stretching under load
  wire ramping = fsm_q == coef_bank_pkg::SW_DOWN ||
                 fsm_q == coef_bank_pkg::SW_UP;
  wire at_base = ramping && sample_tick &&
                 (5'(tick_cnt_q + 5'h01) >= base_div);
  wire extend = at_base && load_stall && ext_step_q < `EXT_MAX &&
                ext_used_q < ext_budget;
  wire step_d = at_base && !extend;
  wire muting = fsm_q == coef_bank_pkg::SW_DOWN ||
                fsm_q == coef_bank_pkg::SW_SWAP ||
                fsm_q == coef_bank_pkg::SW_SILENT;

  // switch sequence: mute ramp, swap, silent start, unmute ramp
  always_comb begin
    fsm_d = fsm_q;
    case (fsm_q)
      coef_bank_pkg::SW_IDLE: begin
        if (switch_req) begin
          fsm_d = clk_present ? coef_bank_pkg::SW_DOWN
                              : coef_bank_pkg::SW_SWAP;
        end
      end
      coef_bank_pkg::SW_DOWN: begin
        if (!clk_present || gain_q == 12'h000) begin
          fsm_d = coef_bank_pkg::SW_SWAP;
        end
      end
      coef_bank_pkg::SW_SWAP: begin
        fsm_d = clk_present ? coef_bank_pkg::SW_UP
                            : coef_bank_pkg::SW_SILENT;
      end
      coef_bank_pkg::SW_SILENT: begin
        if (clk_present && silent_cnt_q >= 32'(SILENT_CYC - 1)) begin
          fsm_d = coef_bank_pkg::SW_UP;
        end
      end
      coef_bank_pkg::SW_UP: begin
        if (!clk_present) begin
          fsm_d = coef_bank_pkg::SW_SILENT;
        end else if (gain_q >= ramp_full) begin
          fsm_d = coef_bank_pkg::SW_IDLE;
        end
      end
      default: fsm_d = coef_bank_pkg::SW_IDLE;
    endcase
  end

  // control registers; the fields reset to manual bank 1
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= coef_bank_pkg::SEL_BANK1;
      assoc1_q <= `ASSOC1_RST;
      assoc2_q <= `ASSOC2_RST;
      steps_code_q <= `STEPS_RST;
    end else begin
      if (wr_bank_ctrl) begin
        sel_q <= coef_bank_pkg::bank_sel_t'(wsel);
        assoc1_q <= reg_req.wdata[`ASSOC1_LSB+7:`ASSOC1_LSB];
        assoc2_q <= reg_req.wdata[`ASSOC2_LSB+7:`ASSOC2_LSB];
      end
      if (wr_vol_ramp && wsteps != 2'h3) begin
        steps_code_q <= wsteps;
      end
    end
  end

  // register read-back with live status
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_req.rd) begin
      reg_rdata_q <= 32'h0000_0000;
      if (reg_req.addr == `BANK_CTRL_ADDR) begin
        reg_rdata_q[`SEL_MSB:`SEL_LSB] <= sel_q;
        reg_rdata_q[`ASSOC1_LSB+7:`ASSOC1_LSB] <= assoc1_q;
        reg_rdata_q[`ASSOC2_LSB+7:`ASSOC2_LSB] <= assoc2_q;
        reg_rdata_q[`ACTIVE_LSB+1:`ACTIVE_LSB] <= active_bank_q;
        reg_rdata_q[`BUSY_BIT] <= switch_busy_q;
      end else if (reg_req.addr == `VOL_RAMP_ADDR) begin
        reg_rdata_q[`STEPS_LSB+1:`STEPS_LSB] <= steps_code_q;
      end
    end
  end

  // state, bank in use and target
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fsm_q <= coef_bank_pkg::SW_IDLE;
      active_bank_q <= 2'h0;
      target_q <= 2'h0;
    end else begin
      fsm_q <= fsm_d;
      if (fsm_q == coef_bank_pkg::SW_IDLE && switch_req) begin
        target_q <= want_bank;
      end
      if (fsm_q == coef_bank_pkg::SW_SWAP && !bank_set_mode) begin
        active_bank_q <= target_q;
      end
    end
  end

  // step divider and stretch accounting
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= 5'h00;
      ext_step_q <= 2'h0;
      ext_used_q <= 13'h0000;
      step_q <= 1'b0;
    end else begin
      step_q <= step_d;
      if (!ramping || step_d) begin
        tick_cnt_q <= 5'h00;
        ext_step_q <= 2'h0;
      end else if (sample_tick) begin
        tick_cnt_q <= 5'(tick_cnt_q + 5'h01);
        if (extend) begin
          ext_step_q <= 2'(ext_step_q + 2'h1);
        end
      end
      if (!ramping) begin
        ext_used_q <= 13'h0000;
      end else if (extend) begin
        ext_used_q <= 13'(ext_used_q + 13'h0001);
      end
    end
  end

  // linear gain: follows full scale when idle, moves one per step
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gain_q <= `STEPS_2048;
      silent_cnt_q <= 32'h0000_0000;
    end else begin
      case (fsm_q)
        coef_bank_pkg::SW_IDLE: gain_q <= ramp_full;
        coef_bank_pkg::SW_DOWN: begin
          if (step_d && gain_q != 12'h000) begin
            gain_q <= 12'(gain_q - 12'h001);
          end
        end
        coef_bank_pkg::SW_UP: begin
          if (step_d && gain_q < ramp_full) begin
            gain_q <= 12'(gain_q + 12'h001);
          end
        end
        default: gain_q <= 12'h000;
      endcase
      if (fsm_q == coef_bank_pkg::SW_SILENT && clk_present) begin
        silent_cnt_q <= 32'(silent_cnt_q + 32'h0000_0001);
      end else begin
        silent_cnt_q <= 32'h0000_0000;
      end
    end
  end

  // per-channel mute and volume; switch mute overrides unmute
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      user_mute_q <= 8'h00;
      chan_mute_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        vol_q[i] <= 8'h00;
      end
    end else begin
      user_mute_q <= (user_mute_q | mute_cmd) & ~unmute_cmd;
      chan_mute_q <= user_mute_q | {8{muting}};
      if (vol_cmd.valid) begin
        vol_q[vol_cmd.chan] <= vol_cmd.level;
      end
    end
  end

  // outputs kept in flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      switch_gain_q <= `STEPS_2048;
      ramp_full_q <= `STEPS_2048;
      switch_busy_q <= 1'b0;
      chan_vol_q <= 64'h0000_0000_0000_0000;
      init_busy_q <= 1'b1;
    end else begin
      switch_gain_q <= gain_q;
      ramp_full_q <= ramp_full;
      switch_busy_q <= fsm_d != coef_bank_pkg::SW_IDLE;
      init_busy_q <= mem_busy;
      for (int i = 0; i < 8; i++) begin
        chan_vol_q[8*i +: 8] <= vol_q[i];
      end
    end
  end

  // bank storage: writes to the write bank, reads from the bank in use
  coef_bank_mem #(
    .WORDS(1 << AW),
    .DATA_W(32)
  ) u_mem (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .wr_en(coef_req.wr),
    .wr_bank(wr_bank),
    .wr_addr(coef_req.addr[AW-1:0]),
    .wr_data(coef_req.data),
    .rd_bank(active_bank_q),
    .rd_addr(coef_rd_addr[AW-1:0]),
    .rd_data_q(coef_rd_data_q),
    .clear_busy_q(mem_busy)
  );

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_down_done;
    fsm_q == coef_bank_pkg::SW_DOWN && gain_q == 12'h000 && clk_present;
  endsequence
  sequence s_swap_then_up;
    fsm_q == coef_bank_pkg::SW_SWAP ##1 fsm_q == coef_bank_pkg::SW_UP;
  endsequence

  a_mute_then_swap: assert property (
    s_down_done ##1 clk_present |-> s_swap_then_up)
    else $error("switch did not swap after reaching mute");
  a_step_holds_gain: assert property (
    fsm_q == coef_bank_pkg::SW_DOWN && !step_d |=> $stable(gain_q))
    else $error("gain moved without a ramp step");
  a_step_spacing: assert property (
    step_d |-> 5'(tick_cnt_q + 5'h01) >= base_div &&
    5'(tick_cnt_q + 5'h01) <= 5'(base_div + 5'h03))
    else $error("ramp step period outside base plus three");
  a_stretch_budget: assert property (
    ext_used_q <= ext_budget)
    else $error("ramp stretch exceeded its budget");
  a_mute_priority: assert property (
    muting && unmute_cmd != 8'h00 ##1 muting |=> chan_mute_q == 8'hFF)
    else $error("unmute got through a switch mute");
  a_bank_set_block: assert property (
    bank_set_mode && fsm_q != coef_bank_pkg::SW_SWAP |=>
    $stable(active_bank_q))
    else $error("bank changed during bank-set mode");
  a_set_write_bank: assert property (
    sel_q == coef_bank_pkg::SEL_SET3 |-> wr_bank == 2'h2)
    else $error("bank-set 3 does not steer writes to bank 3");
  a_auto_first_bank: assert property (
    auto_mode && rate_in_b1 && fsm_q == coef_bank_pkg::SW_IDLE &&
    active_bank_q != 2'h0 && !mem_busy |=>
    fsm_q != coef_bank_pkg::SW_IDLE && target_q == 2'h0)
    else $error("automatic mode skipped an associated bank 1");
  a_stopped_swap: assert property (
    fsm_q == coef_bank_pkg::SW_IDLE && switch_req && !clk_present |=>
    fsm_q == coef_bank_pkg::SW_SWAP ##1
    fsm_q == coef_bank_pkg::SW_SILENT || clk_present)
    else $error("stopped clock switch did not swap at once");
  a_manual_write_bank: assert property (
    sel_q == coef_bank_pkg::SEL_BANK2 && fsm_q == coef_bank_pkg::SW_IDLE
    && !switch_req |-> wr_bank == 2'h1)
    else $error("manual write missed the selected bank");
endmodule

//--- coef_bank_switcher_bench.sv
// self-checking bench of the coefficient bank switcher
// assumes host_ctrl_model drives the control and coefficient ports
`timescale 1ns/1ps
`include "coef_bank_map.svh"
module coef_bank_switcher_bench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  coef_bank_pkg::reg_req_t reg_req;
  coef_bank_pkg::coef_req_t coef_req;
  coef_bank_pkg::rate_t det_rate = coef_bank_pkg::RATE_38;
  coef_bank_pkg::vol_cmd_t vol_cmd = '0;
  logic [31:0] reg_rdata_q, coef_rd_data_q, rd, d1, d2;
  logic [8:0] coef_rd_addr = 9'h000;
  logic sample_tick = 1'b0, clk_present = 1'b0, load_stall = 1'b0;
  logic stall_en = 1'b0;
  logic [7:0] unmute_cmd = 8'h00, mute_cmd = 8'h00, chan_mute_q, m8;
  logic [11:0] switch_gain_q, ramp_full_q;
  logic [63:0] chan_vol_q;
  logic [1:0] active_bank_q;
  logic switch_busy_q, init_busy_q;
  logic [15:0] lfsr = 16'h0028;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;

  coef_bank_switcher #(.SILENT_CYC(20)) dut (.ref_clk(ref_clk),
    .reset_n(reset_n), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
    .coef_req(coef_req), .coef_rd_addr(coef_rd_addr),
    .coef_rd_data_q(coef_rd_data_q), .det_rate(det_rate),
    .sample_tick(sample_tick), .clk_present(clk_present),
    .load_stall(load_stall), .mute_cmd(mute_cmd), .unmute_cmd(unmute_cmd),
    .vol_cmd(vol_cmd), .switch_gain_q(switch_gain_q),
    .ramp_full_q(ramp_full_q), .chan_mute_q(chan_mute_q),
    .chan_vol_q(chan_vol_q), .active_bank_q(active_bank_q),
    .switch_busy_q(switch_busy_q), .init_busy_q(init_busy_q));

  host_ctrl_model host (.ref_clk(ref_clk), .reg_rdata_q(reg_rdata_q),
    .reg_req(reg_req), .coef_req(coef_req));

  // clock
  always #2 ref_clk = ~ref_clk;

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // ramp length for a step code; code 3 leaves 2048 from code 2
  function automatic logic [11:0] full_of(input int c);
    return (c == 0) ? 12'd512 : (c == 1) ? 12'd1024 : 12'd2048;
  endfunction

  // automatic bank choice, bit 7 of each byte is 32 kHz
  function automatic logic [1:0] pick_bank(input logic [2:0] r,
      input logic [7:0] a1, input logic [7:0] a2);
    if (a1[3'd7 - r])
      return 2'd0;
    if (a2[3'd7 - r])
      return 2'd1;
    return 2'd2;
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // sample ticks every other cycle, random stall, hang guard
  always @(posedge ref_clk) begin
    sample_tick <= ~sample_tick;
    lfsr <= lfsr_next(lfsr);
    load_stall <= stall_en & lfsr[0];
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (switch_busy_q !== lvl && n < lim) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check({31'h0, switch_busy_q}, {31'h0, lvl});
  endtask

  task automatic read_coef(input logic [8:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    coef_rd_addr <= a;
    repeat (2) @(posedge ref_clk);
    #1 check(coef_rd_data_q, exp);
  endtask

  // streaming switch: time the fall, then see the swap and the return
  task automatic run_switch(input int div, input logic [1:0] bank);
    int t;
    int n;
    n = 512 * div;
    t = 0;
    wait_busy(1'b1, 20);
    while (switch_gain_q !== 12'h000 && t < 40000) begin
      @(posedge ref_clk);
      #1 t += sample_tick;
    end
    check({31'h0, t >= n - div && t <= n + n / 8 + div}, 1);
    check({24'h0, chan_mute_q}, 32'hFF);
    repeat (3) @(posedge ref_clk);
    check({30'h0, active_bank_q}, {30'h0, bank});
    wait_busy(1'b0, 40000);
    check({20'h0, switch_gain_q}, {20'h0, full_of(0)});
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    host.read_reg(`BANK_CTRL_ADDR, rd);
    check(rd, 32'h0000FF00);
    host.read_reg(`VOL_RAMP_ADDR, rd);
    check(rd, 32'h2);
    host.read_reg(8'h44, rd);
    check(rd, 32'h0);
    for (int c = 0; c < 4; c++) begin
      host.write_reg(`VOL_RAMP_ADDR, c);
      @(posedge ref_clk);
      #1 check({20'h0, ramp_full_q}, {20'h0, full_of(c)});
    end
    host.write_reg(`VOL_RAMP_ADDR, 32'h0);
    for (int n = 0; n < 3000 && init_busy_q !== 1'b0; n++)
      @(posedge ref_clk);
    check({31'h0, init_busy_q}, 32'h0);
    d1 = {lfsr, lfsr_next(lfsr)};
    host.bank_load(coef_bank_pkg::SEL_SET2, coef_bank_pkg::SEL_BANK1,
                   16'hFF00, 9'h005, d1);
    d2 = {lfsr_next(lfsr), lfsr};
    host.bank_load(coef_bank_pkg::SEL_SET1, coef_bank_pkg::SEL_BANK1,
                   16'hFF00, 9'h005, d2);
    check({29'h0, active_bank_q, switch_busy_q}, 32'h0);
    read_coef(9'h005, d2);
    // manual switch to bank 2 with the audio clocks stopped
    host.write_reg(`BANK_CTRL_ADDR, 32'h0001FF00);
    wait_busy(1'b1, 20);
    repeat (3) @(posedge ref_clk);
    check({30'h0, active_bank_q}, 32'h1);
    clk_present <= 1'b1;
    wait_busy(1'b0, 10000);
    read_coef(9'h005, d1);
    // streaming switch to bank 3, volume and unmute during the mute
    stall_en <= 1'b1;
    host.write_reg(`BANK_CTRL_ADDR, 32'h0002FF00);
    wait_busy(1'b1, 20);
    repeat (2) @(posedge ref_clk);
    vol_cmd <= '{valid: 1'b1, chan: 3'd3, level: lfsr[7:0]};
    unmute_cmd <= 8'hFF;
    d1 = {24'h0, lfsr[7:0]};
    @(posedge ref_clk);
    vol_cmd <= '0;
    unmute_cmd <= 8'h00;
    #1 check({24'h0, chan_mute_q}, 32'hFF);
    run_switch(4, 2'd2);
    stall_en <= 1'b0;
    check({24'h0, chan_vol_q[31:24]}, d1);
    check({24'h0, chan_mute_q}, 32'h0);
    // user mute of random channels, then unmute back to the set volume
    @(posedge ref_clk);
    m8 = lfsr[15:8] | 8'h01;
    mute_cmd <= m8;
    @(posedge ref_clk);
    mute_cmd <= 8'h00;
    repeat (2) @(posedge ref_clk);
    #1 check({24'h0, chan_mute_q}, {24'h0, m8});
    @(posedge ref_clk);
    unmute_cmd <= 8'hFF;
    @(posedge ref_clk);
    unmute_cmd <= 8'h00;
    repeat (2) @(posedge ref_clk);
    #1 check({24'h0, chan_mute_q}, 32'h0);
    check({24'h0, chan_vol_q[31:24]}, d1);
    host.write_coef(9'h006, d2);
    read_coef(9'h006, d2);
    // automatic selection, then bank-set holding off a rate change
    host.write_reg(`BANK_CTRL_ADDR, 32'h00038040);
    run_switch(4, pick_bank(det_rate, 8'h80, 8'h40));
    host.write_reg(`BANK_CTRL_ADDR, 32'h00048040);
    det_rate <= coef_bank_pkg::RATE_96;
    repeat (50) @(posedge ref_clk);
    check({29'h0, active_bank_q, switch_busy_q}, 32'h2);
    host.write_reg(`BANK_CTRL_ADDR, 32'h00038040);
    run_switch(8, pick_bank(det_rate, 8'h80, 8'h40));
    host.write_coef(9'h007, d1);
    read_coef(9'h007, d1);
    host.read_reg(`BANK_CTRL_ADDR, rd);
    check(rd, 32'h00238040);
    // back to 32 kHz: automatic mode returns to the associated bank 1
    @(posedge ref_clk);
    det_rate <= coef_bank_pkg::RATE_32;
    run_switch(4, pick_bank(3'h0, 8'h80, 8'h40));
    read_coef(9'h005, d2);
    wrap_up();
  end
endmodule

//--- host_ctrl_model.sv
// host controller model: register and coefficient writes, reads
// assumes its tasks are called from one bench process at a time
`timescale 1ns/1ps
`include "coef_bank_map.svh"
module host_ctrl_model (
  input wire logic ref_clk,
  input wire logic [31:0] reg_rdata_q,
  output coef_bank_pkg::reg_req_t reg_req,
  output coef_bank_pkg::coef_req_t coef_req
);
  initial begin
    reg_req = '0;
    coef_req = '0;
  end

  // one-cycle write strobe, raised and dropped just after edges
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask

  // read strobe; data is registered one cycle later
  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk);
    reg_req <= '0;
    #1 d = reg_rdata_q;
  endtask

  // one coefficient word into the current write bank
  task automatic write_coef(input logic [8:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    coef_req <= '{wr: 1'b1, addr: a, data: d};
    @(posedge ref_clk);
    coef_req <= '0;
  endtask

  // load one word under bank-set, then restore the selection
  task automatic bank_load(input logic [2:0] set_code,
                           input logic [2:0] back,
                           input logic [15:0] assoc,
                           input logic [8:0] a, input logic [31:0] d);
    write_reg(`BANK_CTRL_ADDR, {13'h0, set_code, assoc});
    write_coef(a, d);
    write_reg(`BANK_CTRL_ADDR, {13'h0, back, assoc});
  endtask
endmodule
